// File: pkg/igm_consts.svh
// Offsets, field positions, reset values and timing counts of the interrupt gate.
`ifndef IGM_CONSTS_SVH
`define IGM_CONSTS_SVH
`define IGM_AW            8
`define IGM_A_FLAG        8'h00
`define IGM_A_MASK        8'h04
`define IGM_A_CTRL        8'h08
`define IGM_A_WSP         8'h0C
`define IGM_A_NSP         8'h10
`define IGM_A_STAT        8'h14
`define IGM_A_EVT         8'h18
`define IGM_A_EVTMSK      8'h1C
`define IGM_A_REACH       8'h20
`define IGM_NSRC          4
`define IGM_KEY_BIT       0
`define IGM_CTRL_GIE      0
`define IGM_CTRL_HIOSC    1
`define IGM_CTRL_WDTEN    2
`define IGM_CTRL_WDTRST   3
`define IGM_CTRL_RST      4'h4
`define IGM_EVT_NMI       0
`define IGM_EVT_WAKE      1
`define IGM_EVT_ACK       2
`define IGM_EVT_SPOK      3
`define IGM_WSP_W         13
`define IGM_NSP_W         8
`define IGM_VEC_BASE      16'h0100
`define IGM_VEC_LAST      16'h010F
`define IGM_REACH_BACK    16'h007F
`define IGM_REACH_FWD     16'h0080
`define IGM_RESP_OKAY     2'h0
`define IGM_RESP_SLVERR   2'h2
`define IGM_CLK_HZ        40000000
`define IGM_WDT_PERIOD_S  3
`define IGM_WDT_CYCLES    (`IGM_WDT_PERIOD_S * `IGM_CLK_HZ)
`define IGM_WDT_CW        27
`endif

// File: pkg/igm_pkg.sv
// Types shared by the interrupt gate modules.
package igm_pkg;
  typedef enum logic [1:0] {
    IGM_RUN   = 2'b01,
    IGM_SLEEP = 2'b10
  } igm_pwr_t;
  typedef logic [3:0] igm_src_t;
endpackage

// File: pkg/igm_wdt_if.sv
// Signals between the interrupt gate and its watchdog.
`timescale 1ns/1ps
`default_nettype none
interface igm_wdt_if;
  logic en;
  logic restart;
  logic halt;
  logic nmi;
  modport ctl (output en, output restart, output halt, input nmi);
  modport wdt (input en, input restart, input halt, output nmi);
endinterface
`default_nettype wire

// File: hw/igm_watchdog.sv
// Watchdog counter that raises a non-maskable pulse at the end of each period.
`timescale 1ns/1ps
`default_nettype none
`include "igm_consts.svh"
module igm_watchdog #(
  parameter int unsigned WDT_CYCLES = `IGM_WDT_CYCLES
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic ce,
  igm_wdt_if.wdt    wd
);
  import igm_pkg::*;
  localparam logic [`IGM_WDT_CW-1:0] LAST = `IGM_WDT_CW'(WDT_CYCLES - 1);
  logic [`IGM_WDT_CW-1:0] cnt_r;
  logic [`IGM_WDT_CW-1:0] cnt_nxt;
  logic                   nmi_r;
  logic                   nmi_nxt;

  // The count stands still while the core sleeps, held by the halt input from the gate.
  always_comb begin
    cnt_nxt = cnt_r;
    nmi_nxt = 1'b0;
    if (wd.restart || !wd.en) begin
      cnt_nxt = '0;
    end else if (!wd.halt) begin
      if (cnt_r == LAST) begin
        cnt_nxt = '0;
        nmi_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      nmi_r <= 1'b0;
    end else if (ce) begin
      cnt_r <= cnt_nxt;
      nmi_r <= nmi_nxt;
    end
  end

  assign wd.nmi = nmi_r;

  sequence s_expire;
    ce && wd.en && !wd.restart && !wd.halt && cnt_r == LAST;
  endsequence
  a_wdt_fires: assert property (@(posedge clk) disable iff (sys_rst)
    s_expire |=> nmi_r && cnt_r == '0)
    else $error("Watchdog did not fire at the end of its period.");
endmodule
`default_nettype wire

// File: hw/igm_gate.sv
// Interrupt gate: factor flags, stack pointer interlock, sleep and watchdog NMI.
`timescale 1ns/1ps
`default_nettype none
`include "igm_consts.svh"
module igm_gate #(
  parameter int unsigned WDT_CYCLES = `IGM_WDT_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    ce,
  input  wire logic [`IGM_AW-1:0]      s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`IGM_AW-1:0]      s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire igm_pkg::igm_src_t       factor_cond,
  input  wire logic                    int_ack,
  input  wire logic                    nmi_ack,
  input  wire logic                    return_from_interrupt_op,
  input  wire logic                    sleep_instruction,
  input  wire logic                    wsp_inc,
  input  wire logic                    wsp_dec,
  input  wire logic                    nsp_inc,
  input  wire logic                    nsp_dec,
  output logic                         int_req,
  output logic [15:0]                  int_vec,
  output logic                         nmi_req,
  output logic                         low_speed_oscillator_en,
  output logic                         high_speed_oscillator_en,
  output logic                         irq
);
  import igm_pkg::*;

  igm_wdt_if wd ();

  igm_watchdog #(.WDT_CYCLES(WDT_CYCLES)) igm_watchdog_i (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .wd      (wd)
  );

  // Merges the written byte lanes into the old register value.
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Handler target lies within -7FH..+80H of the vector.
  function automatic logic in_reach(input logic [15:0] vec, input logic [15:0] tgt);
    return (tgt >= vec - `IGM_REACH_BACK) && (tgt <= vec + `IGM_REACH_FWD);
  endfunction

  // Vector of a maskable source; the NMI owns the base address.
  function automatic logic [15:0] src_vec(input logic [2:0] idx);
    return `IGM_VEC_BASE + {12'h000, idx + 3'd1, 1'b0};
  endfunction

  // Bus state.
  logic [`IGM_AW-1:0] waddr_r, waddr_nxt;
  logic [31:0]        wdata_r, wdata_nxt;
  logic [3:0]         wstrb_r, wstrb_nxt;
  logic               aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic               awready_r, awready_nxt, wready_r, wready_nxt;
  logic               bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic               rvalid_r, rvalid_nxt;
  logic [1:0]         bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  // Block state.
  igm_src_t           flag_r, flag_nxt, mask_r, mask_nxt, flag_clr;
  logic [3:0]         ctrl_r, ctrl_nxt, evt_r, evt_nxt, evtmsk_r, evtmsk_nxt, evt_set;
  logic [`IGM_WSP_W-1:0] wsp_r, wsp_nxt;
  logic [`IGM_NSP_W-1:0] nsp_r, nsp_nxt;
  logic               wsp_ok_r, wsp_ok_nxt, nsp_ok_r, nsp_ok_nxt, sp_ok;
  logic               nmi_pend_r, nmi_pend_nxt, wdt_rst_r, wdt_rst_nxt;
  logic [15:0]        reach_tgt_r, reach_tgt_nxt;
  logic [2:0]         reach_src_r, reach_src_nxt;
  igm_pwr_t           pwr_r, pwr_nxt;
  logic               int_req_r, int_req_nxt, nmi_req_r, nmi_req_nxt;
  logic [15:0]        int_vec_r, int_vec_nxt;
  logic               lo_osc_r, lo_osc_nxt, hi_osc_r, hi_osc_nxt, irq_r, irq_nxt;
  logic               do_wr, do_rd, wr_hit;
  logic [31:0]        wv;
  igm_src_t           pend;

  assign sp_ok = wsp_ok_r && nsp_ok_r;
  assign do_wr = aw_held_r && w_held_r && !bvalid_r;
  assign do_rd = s_axi_arvalid && arready_r;
  assign pend  = flag_r & mask_r;

  always_comb begin
    waddr_nxt     = waddr_r;
    wdata_nxt     = wdata_r;
    wstrb_nxt     = wstrb_r;
    aw_held_nxt   = aw_held_r;
    w_held_nxt    = w_held_r;
    bvalid_nxt    = bvalid_r;
    bresp_nxt     = bresp_r;
    rvalid_nxt    = rvalid_r;
    rresp_nxt     = rresp_r;
    rdata_nxt     = rdata_r;
    flag_clr      = '0;
    mask_nxt      = mask_r;
    ctrl_nxt      = ctrl_r;
    evtmsk_nxt    = evtmsk_r;
    wsp_nxt       = wsp_r;
    nsp_nxt       = nsp_r;
    wsp_ok_nxt    = wsp_ok_r;
    nsp_ok_nxt    = nsp_ok_r;
    reach_tgt_nxt = reach_tgt_r;
    reach_src_nxt = reach_src_r;
    wdt_rst_nxt   = 1'b0;
    wr_hit        = 1'b1;
    wv            = '0;
    // Address and data are taken in either order and held until the write is done.
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      case (waddr_r)
        `IGM_A_FLAG: begin
          wv       = apply_strb(32'h0, wdata_r, wstrb_r);
          flag_clr = wv[`IGM_NSRC-1:0];
        end
        `IGM_A_MASK: begin
          wv       = apply_strb({28'h0, mask_r}, wdata_r, wstrb_r);
          mask_nxt = wv[3:0];
        end
        `IGM_A_CTRL: begin
          wv          = apply_strb({28'h0, ctrl_r}, wdata_r, wstrb_r);
          ctrl_nxt    = {1'b0, wv[2:0]};
          wdt_rst_nxt = wv[`IGM_CTRL_WDTRST];
        end
        `IGM_A_WSP: begin
          wv      = apply_strb({19'h0, wsp_r}, wdata_r, wstrb_r);
          wsp_nxt = wv[`IGM_WSP_W-1:0];
          // Rewriting one valid pointer reopens the pair.
          if (sp_ok) begin
            nsp_ok_nxt = 1'b0;
          end else begin
            wsp_ok_nxt = 1'b1;
          end
        end
        `IGM_A_NSP: begin
          wv      = apply_strb({24'h0, nsp_r}, wdata_r, wstrb_r);
          nsp_nxt = wv[`IGM_NSP_W-1:0];
          if (sp_ok) begin
            wsp_ok_nxt = 1'b0;
          end else begin
            nsp_ok_nxt = 1'b1;
          end
        end
        `IGM_A_EVTMSK: begin
          wv         = apply_strb({28'h0, evtmsk_r}, wdata_r, wstrb_r);
          evtmsk_nxt = wv[3:0];
        end
        `IGM_A_REACH: begin
          wv            = apply_strb({13'h0, reach_src_r, reach_tgt_r}, wdata_r, wstrb_r);
          reach_tgt_nxt = wv[15:0];
          reach_src_nxt = wv[18:16];
        end
        `IGM_A_STAT, `IGM_A_EVT: begin
          wr_hit = 1'b1;
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      bresp_nxt = wr_hit ? `IGM_RESP_OKAY : `IGM_RESP_SLVERR;
    end
    // Acceptance drops the global enable; return or a software write restores it.
    if (int_ack) begin
      ctrl_nxt[`IGM_CTRL_GIE] = 1'b0;
    end
    if (return_from_interrupt_op) begin
      ctrl_nxt[`IGM_CTRL_GIE] = 1'b1;
    end
    // Stack pointer moves by the core, wrapping within each pointer's width.
    if (!(do_wr && waddr_r == `IGM_A_WSP)) begin
      if (wsp_inc) begin
        wsp_nxt = wsp_r + 1'b1;
      end else if (wsp_dec) begin
        wsp_nxt = wsp_r - 1'b1;
      end
    end
    if (!(do_wr && waddr_r == `IGM_A_NSP)) begin
      if (nsp_inc) begin
        nsp_nxt = nsp_r + 1'b1;
      end else if (nsp_dec) begin
        nsp_nxt = nsp_r - 1'b1;
      end
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (do_rd) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `IGM_RESP_OKAY;
      case (s_axi_araddr)
        `IGM_A_FLAG:   rdata_nxt = {28'h0, flag_r};
        `IGM_A_MASK:   rdata_nxt = {28'h0, mask_r};
        `IGM_A_CTRL:   rdata_nxt = {28'h0, ctrl_r};
        `IGM_A_WSP:    rdata_nxt = {19'h0, wsp_r};
        `IGM_A_NSP:    rdata_nxt = {24'h0, nsp_r};
        `IGM_A_STAT:   rdata_nxt = {26'h0, pwr_r == IGM_SLEEP, nmi_pend_r, int_req_r,
                                    nsp_ok_r, wsp_ok_r, sp_ok};
        `IGM_A_EVT:    rdata_nxt = {28'h0, evt_r};
        `IGM_A_EVTMSK: rdata_nxt = {28'h0, evtmsk_r};
        `IGM_A_REACH:  rdata_nxt = {12'h000, in_reach(src_vec(reach_src_r), reach_tgt_r),
                                    reach_src_r, reach_tgt_r};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = `IGM_RESP_SLVERR;
        end
      endcase
    end
    awready_nxt = !aw_held_nxt && !bvalid_nxt;
    wready_nxt  = !w_held_nxt && !bvalid_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_comb begin
    // Conditions latch whatever the mask says; a new event beats a clear.
    flag_nxt     = (flag_r & ~flag_clr) | factor_cond;
    nmi_pend_nxt = (nmi_pend_r && !nmi_ack) || wd.nmi;
    pwr_nxt      = pwr_r;
    lo_osc_nxt   = lo_osc_r;
    hi_osc_nxt   = hi_osc_r;
    case (pwr_r)
      IGM_RUN: begin
        lo_osc_nxt = 1'b1;
        hi_osc_nxt = ctrl_nxt[`IGM_CTRL_HIOSC];
        if (sleep_instruction) begin
          pwr_nxt    = IGM_SLEEP;
          lo_osc_nxt = 1'b0;
          hi_osc_nxt = 1'b0;
        end
      end
      IGM_SLEEP: begin
        if (flag_nxt[`IGM_KEY_BIT] && !flag_r[`IGM_KEY_BIT]) begin
          pwr_nxt    = IGM_RUN;
          lo_osc_nxt = 1'b1;
          hi_osc_nxt = ctrl_r[`IGM_CTRL_HIOSC];
        end
      end
      default: begin
        pwr_nxt = IGM_RUN;
      end
    endcase
    int_req_nxt = (|pend) && ctrl_r[`IGM_CTRL_GIE] && sp_ok && pwr_r == IGM_RUN;
    nmi_req_nxt = nmi_pend_r && sp_ok && pwr_r == IGM_RUN;
    int_vec_nxt = `IGM_VEC_BASE;
    for (int i = `IGM_NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        int_vec_nxt = src_vec(3'(i));
      end
    end
    evt_set[`IGM_EVT_NMI]  = wd.nmi;
    evt_set[`IGM_EVT_WAKE] = pwr_r == IGM_SLEEP && pwr_nxt == IGM_RUN;
    evt_set[`IGM_EVT_ACK]  = int_ack;
    evt_set[`IGM_EVT_SPOK] = !sp_ok && wsp_ok_nxt && nsp_ok_nxt;
    evt_nxt = ((do_rd && s_axi_araddr == `IGM_A_EVT) ? 4'h0 : evt_r) | evt_set;
    irq_nxt = |(evt_nxt & evtmsk_nxt);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waddr_r     <= '0;
      wdata_r     <= '0;
      wstrb_r     <= '0;
      aw_held_r   <= 1'b0;
      w_held_r    <= 1'b0;
      awready_r   <= 1'b0;
      wready_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `IGM_RESP_OKAY;
      arready_r   <= 1'b0;
      rvalid_r    <= 1'b0;
      rresp_r     <= `IGM_RESP_OKAY;
      rdata_r     <= '0;
      flag_r      <= '0;
      mask_r      <= '0;
      ctrl_r      <= `IGM_CTRL_RST;
      evt_r       <= '0;
      evtmsk_r    <= '0;
      wsp_r       <= '0;
      nsp_r       <= '0;
      wsp_ok_r    <= 1'b0;
      nsp_ok_r    <= 1'b0;
      nmi_pend_r  <= 1'b0;
      wdt_rst_r   <= 1'b0;
      reach_tgt_r <= '0;
      reach_src_r <= '0;
      pwr_r       <= IGM_RUN;
      int_req_r   <= 1'b0;
      nmi_req_r   <= 1'b0;
      int_vec_r   <= `IGM_VEC_BASE;
      lo_osc_r    <= 1'b1;
      hi_osc_r    <= 1'b0;
      irq_r       <= 1'b0;
    end else if (ce) begin
      waddr_r     <= waddr_nxt;
      wdata_r     <= wdata_nxt;
      wstrb_r     <= wstrb_nxt;
      aw_held_r   <= aw_held_nxt;
      w_held_r    <= w_held_nxt;
      awready_r   <= awready_nxt;
      wready_r    <= wready_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      arready_r   <= arready_nxt;
      rvalid_r    <= rvalid_nxt;
      rresp_r     <= rresp_nxt;
      rdata_r     <= rdata_nxt;
      flag_r      <= flag_nxt;
      mask_r      <= mask_nxt;
      ctrl_r      <= ctrl_nxt;
      evt_r       <= evt_nxt;
      evtmsk_r    <= evtmsk_nxt;
      wsp_r       <= wsp_nxt;
      nsp_r       <= nsp_nxt;
      wsp_ok_r    <= wsp_ok_nxt;
      nsp_ok_r    <= nsp_ok_nxt;
      nmi_pend_r  <= nmi_pend_nxt;
      wdt_rst_r   <= wdt_rst_nxt;
      reach_tgt_r <= reach_tgt_nxt;
      reach_src_r <= reach_src_nxt;
      pwr_r       <= pwr_nxt;
      int_req_r   <= int_req_nxt;
      nmi_req_r   <= nmi_req_nxt;
      int_vec_r   <= int_vec_nxt;
      lo_osc_r    <= lo_osc_nxt;
      hi_osc_r    <= hi_osc_nxt;
      irq_r       <= irq_nxt;
    end
  end

  assign wd.en                    = ctrl_r[`IGM_CTRL_WDTEN];
  assign wd.restart               = wdt_rst_r;
  assign wd.halt                  = pwr_r == IGM_SLEEP;
  assign s_axi_awready            = awready_r;
  assign s_axi_wready             = wready_r;
  assign s_axi_bresp              = bresp_r;
  assign s_axi_bvalid             = bvalid_r;
  assign s_axi_arready            = arready_r;
  assign s_axi_rdata              = rdata_r;
  assign s_axi_rresp              = rresp_r;
  assign s_axi_rvalid             = rvalid_r;
  assign int_req                  = int_req_r;
  assign int_vec                  = int_vec_r;
  assign nmi_req                  = nmi_req_r;
  assign low_speed_oscillator_en  = lo_osc_r;
  assign high_speed_oscillator_en = hi_osc_r;
  assign irq                      = irq_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_flag_latch: assert property (ce && factor_cond[1] |=> flag_r[1])
    else $error("Factor flag missed its condition.");
  a_flag_clear: assert property (ce && flag_clr[2] && !factor_cond[2] |=> !flag_r[2])
    else $error("Write of one did not clear the factor flag.");
  a_req_cause: assert property (int_req_r && $past(ce) |->
    $past(|pend && ctrl_r[`IGM_CTRL_GIE] && sp_ok))
    else $error("Request raised without flag, mask and global enable.");
  a_req_again: assert property (ce && |pend && ctrl_r[`IGM_CTRL_GIE] && sp_ok &&
    pwr_r == IGM_RUN |=> int_req_r)
    else $error("Pending flag did not raise its request again.");
  a_nmi_locked: assert property (nmi_req_r && $past(ce) |-> $past(sp_ok))
    else $error("NMI passed before both stack pointers were set.");
  a_sp_pair: assert property (ce && do_wr && waddr_r == `IGM_A_NSP && sp_ok
    |=> !sp_ok ##1 !int_req_r && !nmi_req_r)
    else $error("Single stack pointer rewrite did not mask interrupts.");
  a_wsp_wrap: assert property (ce && wsp_inc && wsp_r == 13'h1FFF &&
    !(do_wr && waddr_r == `IGM_A_WSP) |=> wsp_r == 13'h0000)
    else $error("Word stack pointer did not wrap.");
  a_vec_range: assert property (int_req_r |-> int_vec_r > `IGM_VEC_BASE &&
    int_vec_r <= `IGM_VEC_LAST)
    else $error("Vector outside its region.");
  a_sleep_osc: assert property (ce && pwr_r == IGM_RUN && sleep_instruction
    |=> !low_speed_oscillator_en && !high_speed_oscillator_en)
    else $error("Oscillators kept running in sleep.");
  a_sleep_hold: assert property (ce && pwr_r == IGM_SLEEP && !factor_cond[`IGM_KEY_BIT]
    |=> pwr_r == IGM_SLEEP)
    else $error("Sleep left without a key factor.");
endmodule
`default_nettype wire

// File: verification/igm_gate_tb_top.sv
// Self-checking testbench of the interrupt gate.
`timescale 1ns/1ps
`default_nettype none
`include "igm_consts.svh"
module igm_gate_tb_top;
  import igm_pkg::*;
  logic               clk, sys_rst, ce;
  logic [3:0]         wstrb;
  logic [`IGM_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata, rv;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rr;
  logic               s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic               int_req, nmi_req, low_speed_oscillator_en, high_speed_oscillator_en, irq;
  logic [15:0]        int_vec;
  igm_src_t           factor_cond;
  logic [7:0]         pv;
  int                 fails, n_tests;

  // Pulse bits: ack, nmi ack, return, sleep, word inc/dec, nibble inc/dec.
  igm_gate #(.WDT_CYCLES(64)) igm_gate_i (
    .clk, .sys_rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(wstrb), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .factor_cond,
    .int_ack(pv[0]), .nmi_ack(pv[1]), .return_from_interrupt_op(pv[2]),
    .sleep_instruction(pv[3]), .wsp_inc(pv[4]), .wsp_dec(pv[5]), .nsp_inc(pv[6]),
    .nsp_dec(pv[7]), .int_req, .int_vec, .nmi_req, .low_speed_oscillator_en,
    .high_speed_oscillator_en, .irq
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask

  task automatic test_done();
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k == 40) fails++;
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k == 40) fails++;
  endtask

  task automatic pl(input logic [7:0] p, input logic [3:0] f);
    @(posedge clk);
    pv <= p;
    factor_cond <= f;
    @(posedge clk);
    pv <= 8'h00;
    factor_cond <= 4'h0;
    cyc(2);
  endtask

  task automatic t_reset();
    cyc(80);
    chk("nmi_req", 32'h0, {31'h0, nmi_req});
    chk("low_osc", 32'h1, {31'h0, low_speed_oscillator_en});
    rd(`IGM_A_CTRL);
    chk("ctrl", 32'h4, rv);
    rd(`IGM_A_EVT);
    chk("evt_wdt", 32'h1, rv);
  endtask

  task automatic t_pair();
    wr(`IGM_A_CTRL, 32'h0);
    pl(8'h00, 4'h2);
    rd(`IGM_A_FLAG);
    chk("flag", 32'h2, rv);
    wr(`IGM_A_MASK, 32'h2);
    wr(`IGM_A_CTRL, 32'h1);
    wr(`IGM_A_WSP, 32'h100);
    cyc(2);
    chk("req_one_sp", 32'h0, {30'h0, nmi_req, int_req});
    wr(`IGM_A_NSP, 32'h40);
    cyc(2);
    chk("req_both_sp", 32'h3, {30'h0, nmi_req, int_req});
    chk("vec", 32'h104, {16'h0, int_vec});
    pl(8'h02, 4'h0);
    chk("nmi_ack", 32'h0, {31'h0, nmi_req});
  endtask

  task automatic t_again();
    wr(`IGM_A_WSP, 32'h1F0);
    cyc(2);
    chk("req_rewrite", 32'h0, {31'h0, int_req});
    wr(`IGM_A_NSP, 32'h30);
    cyc(2);
    chk("req_pair", 32'h1, {31'h0, int_req});
    pl(8'h01, 4'h0);
    chk("req_ack", 32'h0, {31'h0, int_req});
    pl(8'h04, 4'h0);
    chk("req_return_from_interrupt_op", 32'h1, {31'h0, int_req});
    wr(`IGM_A_FLAG, 32'h2);
    cyc(2);
    chk("req_clr", 32'h0, {31'h0, int_req});
    pl(8'h00, 4'h1);
    chk("req_unmasked", 32'h0, {31'h0, int_req});
    rd(`IGM_A_FLAG);
    chk("flag_key", 32'h1, rv);
    wr(`IGM_A_FLAG, 32'h1);
  endtask

  task automatic t_ptr();
    wr(`IGM_A_NSP, 32'hFF);
    wr(`IGM_A_WSP, 32'h1FFF);
    pl(8'h50, 4'h0);
    rd(`IGM_A_WSP);
    chk("wsp_wrap", 32'h0, rv);
    rd(`IGM_A_NSP);
    chk("nsp_wrap", 32'h0, rv);
    pl(8'hA0, 4'h0);
    rd(`IGM_A_WSP);
    chk("wsp_back", 32'h1FFF, rv);
    rd(`IGM_A_NSP);
    chk("nsp_back", 32'hFF, rv);
  endtask

  task automatic t_reach();
    logic [15:0] tg[4];
    tg = '{16'h182, 16'h183, 16'h083, 16'h082};
    for (int i = 0; i < 4; i++) begin
      wr(`IGM_A_REACH, {16'h0, tg[i]});
      rd(`IGM_A_REACH);
      chk("reach", {12'h0, (i % 2 == 0) ? 4'h8 : 4'h0, tg[i]}, rv);
    end
    wstrb <= 4'h1;
    wr(`IGM_A_REACH, 32'h0007_0011);
    wstrb <= 4'hF;
    rd(`IGM_A_REACH);
    chk("reach_strb", 32'h0000_0011, rv);
  endtask

  task automatic t_wdt();
    wr(`IGM_A_CTRL, 32'h4);
    repeat (3) begin
      cyc(40);
      wr(`IGM_A_CTRL, 32'hC);
    end
    chk("nmi_restart", 32'h0, {31'h0, nmi_req});
    @(posedge clk);
    ce <= 1'b0;
    cyc(100);
    chk("nmi_frozen", 32'h0, {31'h0, nmi_req});
    ce <= 1'b1;
    cyc(70);
    chk("nmi_fire", 32'h1, {31'h0, nmi_req});
    rd(`IGM_A_STAT);
    chk("stat", 32'h17, rv);
    pl(8'h02, 4'h0);
    wr(`IGM_A_CTRL, 32'h0);
  endtask

  task automatic t_sleep();
    wr(`IGM_A_CTRL, 32'h3);
    cyc(2);
    chk("hosc_on", 32'h1, {31'h0, high_speed_oscillator_en});
    pl(8'h08, 4'h0);
    chk("osc_sleep", 32'h0, {30'h0, low_speed_oscillator_en, high_speed_oscillator_en});
    pl(8'h00, 4'h2);
    chk("osc_nokey", 32'h0, {30'h0, low_speed_oscillator_en, high_speed_oscillator_en});
    pl(8'h00, 4'h1);
    chk("osc_wake", 32'h3, {30'h0, low_speed_oscillator_en, high_speed_oscillator_en});
    wr(`IGM_A_FLAG, 32'hF);
  endtask

  task automatic t_evt();
    wr(`IGM_A_EVTMSK, 32'h0);
    rd(`IGM_A_EVT);
    pl(8'h01, 4'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(`IGM_A_EVTMSK, 32'h4);
    cyc(2);
    chk("irq_on", 32'h1, {31'h0, irq});
    rd(`IGM_A_EVT);
    chk("evt_ack", 32'h4, rv);
    cyc(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
    rd(8'h40);
    chk("rresp", 32'h2, {30'h0, rr});
    chk("rdata", 32'h0, rv);
    wr(8'h40, 32'hFFFF_FFFF);
    chk("bresp", 32'h2, {30'h0, rr});
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'b10000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_rready} = '0;
    {factor_cond, pv, fails, n_tests} = '0;
    {ce, wstrb} = 5'h1F;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_pair();
    t_again();
    t_ptr();
    t_reach();
    t_sleep();
    t_evt();
    t_wdt();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
